// ---- verilog/scl_params.svh ----
// Purpose: Offsets, field positions, reset values and counts of the serializer block.
// Assumes: Included by bare name from the design file and the bench.
// Notes:   Definitions only.
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

`define SCL_CTRL_OFS   8'h00
`define SCL_STAT_OFS   8'h04
`define SCL_CTRL_RST   8'h40
`define SCL_B_LOOP_TIMING_SELECT 0
`define SCL_B_BYPASS   1
`define SCL_B_REMOTE   2
`define SCL_B_DIGITAL  3
`define SCL_B_ANALOG   4
`define SCL_B_HIRATE   5
`define SCL_B_CLKOUT   6
`define SCL_B_TXEN     7
`define SCL_S_LOCKED   0
`define SCL_S_UNDERRUN 1
`define SCL_S_OVERFLOW 2
`define SCL_WORD_BITS  8
`define SCL_HI_DIV     2
`define SCL_LO_DIV     8
`define SCL_LOCK_EDGES 4
`define SCL_FIFO_DEPTH 8

`endif

// ---- verilog/scl_pkg.sv ----
// Purpose: Shared types of the serializer block.
// Assumes: Nothing is imported; users write scl_pkg::name.
// Notes:   Constants live in scl_params.svh.
package scl_pkg;
    // Source of the serializer's bit strobe, chosen by loop timing and bypass.
    typedef enum logic [1:0] {SRC_MULT, SRC_CDR, SRC_EXT} scl_src_t;
endpackage

// ---- verilog/scl_loopback_ctrl.sv ----
// Purpose: Byte serializer with clock-source selection and loopback steering.
// Assumes: All pins synchronous to ref_clk; bit clocks are strobes on ref_clk.
// Notes:   Line rates are scaled by divider parameters; the ratio is kept.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "scl_params.svh"

// ----------------------------------------------------------------
// Word FIFO between the capture register and the serializer.
// ----------------------------------------------------------------
module scl_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 8
) (
    input  wire logic                 ref_clk,  // Clock.
    input  wire logic                 rst,      // Synchronous reset.
    input  wire logic                 clkEn,    // Freezes all state when low.
    input  wire logic                 inValid,  // Write request.
    output logic                      inReady,  // Not full.
    input  wire logic [W-1:0]         inData,   // Write data.
    output logic                      outValid, // Not empty.
    input  wire logic                 outReady, // Read request.
    output logic [W-1:0]              outData,  // Head word.
    output logic [$clog2(D):0]        level     // Words held.
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic          push;
    logic          pop;

    // Full and empty come straight from the word count.
    assign inReady  = (level != (AW+1)'(D));
    assign outValid = (level != '0);
    assign outData  = mem[rdPtr];
    assign push     = clkEn && inValid && inReady;
    assign pop      = clkEn && outReady && outValid;

    // Storage array.
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr <= (wrPtr == AW'(D-1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop)
            begin
                rdPtr <= (rdPtr == AW'(D-1)) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    // Word count.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            level <= '0;
        end
        else if (push && !pop)
        begin
            level <= level + 1'b1;
        end
        else if (pop && !push)
        begin
            level <= level - 1'b1;
        end
    end
endmodule

// Summary of operation
// - Serialize bit 7 first down to bit 0.
// - Bit rate is eight times word rate.
// - Multiplier locks to reference, makes bit clock.
// - Reference inputs combined through exclusive-NOR.
// - Loop timing uses internally recovered clock.
// - Bypass samples receive on external clock rise.
// - Bypass plus loop timing transmits external clock.
// - Transmit source multiplier, internal or external.
// - Remote loop sends received bits, recovered clock.
// - Remote loop still deserializes, word clock divided.
// - Digital loop feeds serializer into receive.
// - Digital loop keeps transmitting on selected transmit clock.
// - Analog loop feeds transmit stream to recovery.
// - Remote plus digital gives split loopback.
// - Output word clock is bit clock divided eight.
// - Words captured on word clock rising edge.
// - Direction low makes word clock an input.
module scl_loopback_ctrl #(
    parameter int unsigned HI_DIV     = `SCL_HI_DIV,
    parameter int unsigned LO_DIV     = `SCL_LO_DIV,
    parameter int unsigned LOCK_EDGES = `SCL_LOCK_EDGES,
    parameter int unsigned FIFO_DEPTH = `SCL_FIFO_DEPTH
) (
    input  wire logic        ref_clk,                  // 100 MHz clock.
    input  wire logic        rst,                      // Synchronous reset, high.
    input  wire logic        clkEn,                    // Freezes all state when low.
    input  wire logic        wb_cyc_i,                 // Wishbone cycle.
    input  wire logic        wb_stb_i,                 // Wishbone strobe.
    input  wire logic        wb_we_i,                  // Wishbone write.
    input  wire logic [7:0]  wb_adr_i,                 // Byte address.
    input  wire logic [3:0]  wb_sel_i,                 // Byte lanes.
    input  wire logic [31:0] wb_dat_i,                 // Write data.
    output logic      [31:0] wb_dat_o,                 // Read data.
    output logic             wb_ack_o,                 // Acknowledge.
    input  wire logic        diffRefClockIn,           // Differential reference.
    input  wire logic        singleEndedRefClockIn,    // Single-ended reference.
    input  wire logic        serialRxIn,               // Serial receive data.
    input  wire logic        externalRecoveredClockIn, // External recovered clock.
    input  wire logic [7:0]  txParallelData,           // Transmit word.
    input  wire logic        txWordClockIn,            // Word clock pin, input side.
    output logic             txWordClockOut,           // Word clock pin, output side.
    output logic             txWordClockOe_n,          // Low while driving the pin.
    output logic             txDataReady,              // FIFO can take a word.
    output logic             serialTxOut,              // Serial transmit data.
    output logic      [7:0]  rxParallelData,           // Received word.
    output logic             rxWordClockOut            // Receive word clock.
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] ctrl;
    logic       underrun;
    logic       overflow;
    logic       refComb;
    logic       refPrev;
    logic [7:0] refEdgeCnt;
    logic       locked;
    logic [7:0] divSel;
    logic [7:0] multCnt;
    logic       multStrobe;
    logic       cdrIn;
    logic       cdrPrev;
    logic [7:0] cdrCnt;
    logic       cdrStrobe;
    logic       cdrBit;
    logic       extPrev;
    logic       extStrobe;
    logic       extBit;
    logic       recStrobe;
    logic       recBit;
    logic       serStrobe;
    logic       txStrobe;
    logic [2:0] bitCnt;
    logic [7:0] shReg;
    logic       loadSlot;
    logic       wcPrev;
    logic       wordCap;
    logic       pushValid;
    logic [7:0] pushData;
    logic       fifoInReady;
    logic       fifoOutValid;
    logic [7:0] fifoOutData;
    logic       fifoPop;
    logic [$clog2(FIFO_DEPTH):0] fifoLevel;
    logic       rxStrobe;
    logic       rxBitIn;
    logic [2:0] rxCnt;
    logic [6:0] rxSh;
    logic       wbReq;
    logic       loop_timing_select;
    logic       bypass;
    logic       remote;
    logic       digital;
    logic       txEn;
    scl_pkg::scl_src_t txSrc;

    assign loop_timing_select = ctrl[`SCL_B_LOOP_TIMING_SELECT];
    assign bypass   = ctrl[`SCL_B_BYPASS];
    assign remote   = ctrl[`SCL_B_REMOTE];
    assign digital  = ctrl[`SCL_B_DIGITAL];
    assign txEn     = ctrl[`SCL_B_TXEN];

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // One-cycle answer; unmapped addresses ack with zero and drop writes.
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else if (clkEn)
        begin
            wb_ack_o <= wbReq;
            wb_dat_o <= '0;
            if (wbReq && !wb_we_i && wb_adr_i == `SCL_CTRL_OFS)
            begin
                wb_dat_o <= {24'h000000, ctrl};
            end
            else if (wbReq && !wb_we_i && wb_adr_i == `SCL_STAT_OFS)
            begin
                wb_dat_o <= {16'h0000, rxParallelData, 4'(fifoLevel),
                             1'b0, overflow, underrun, locked};
            end
        end
    end

    // Select levels are meant to be static; a change may glitch the line.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl <= `SCL_CTRL_RST;
        end
        else if (clkEn && wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == `SCL_CTRL_OFS)
        begin
            ctrl <= wb_dat_i[7:0];
        end
    end

    // Sticky errors clear on a written one; a new event wins over the clear.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            underrun <= 1'b0;
            overflow <= 1'b0;
        end
        else if (clkEn)
        begin
            if (wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == `SCL_STAT_OFS)
            begin
                underrun <= underrun & ~wb_dat_i[`SCL_S_UNDERRUN];
                overflow <= overflow & ~wb_dat_i[`SCL_S_OVERFLOW];
            end
            if (loadSlot && txEn && !fifoOutValid)
            begin
                underrun <= 1'b1;
            end
            if (pushValid && !fifoInReady)
            begin
                overflow <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock multiplier
    // ----------------------------------------------------------------
    // Grounding one reference input passes the other, inverted, through the XNOR.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            refComb    <= 1'b0;
            refPrev    <= 1'b0;
            refEdgeCnt <= '0;
            locked     <= 1'b0;
        end
        else if (clkEn)
        begin
            refComb <= ~(diffRefClockIn ^ singleEndedRefClockIn);
            refPrev <= refComb;
            if (!locked && refComb && !refPrev)
            begin
                refEdgeCnt <= refEdgeCnt + 1'b1;
                locked     <= (refEdgeCnt == 8'(LOCK_EDGES - 1));
            end
        end
    end

    // Bit period in ref_clk cycles; high rate is four times the low rate.
    assign divSel = ctrl[`SCL_B_HIRATE] ? 8'(HI_DIV) : 8'(LO_DIV);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            multCnt    <= '0;
            multStrobe <= 1'b0;
        end
        else if (clkEn)
        begin
            multStrobe <= locked && multCnt == '0;
            if (!locked || multCnt == '0)
            begin
                multCnt <= divSel - 8'h01;
            end
            else
            begin
                multCnt <= multCnt - 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock recovery, internal and external
    // ----------------------------------------------------------------
    // Analog loop puts the transmitted stream on the recovery input.
    assign cdrIn = ctrl[`SCL_B_ANALOG] ? serialTxOut : serialRxIn;

    // Phase counter restarts on each data edge and strobes mid-bit.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cdrPrev   <= 1'b0;
            cdrCnt    <= '0;
            cdrStrobe <= 1'b0;
            cdrBit    <= 1'b0;
        end
        else if (clkEn)
        begin
            cdrPrev   <= cdrIn;
            cdrStrobe <= !bypass && cdrCnt == (divSel >> 1);
            if (bypass || cdrIn != cdrPrev || cdrCnt == divSel - 8'h01)
            begin
                cdrCnt <= '0;
            end
            else
            begin
                cdrCnt <= cdrCnt + 8'h01;
            end
            if (cdrCnt == (divSel >> 1))
            begin
                cdrBit <= cdrIn;
            end
        end
    end

    // External clock: receive data is taken at its rising edge.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            extPrev   <= 1'b0;
            extStrobe <= 1'b0;
            extBit    <= 1'b0;
        end
        else if (clkEn)
        begin
            extPrev   <= externalRecoveredClockIn;
            extStrobe <= bypass && externalRecoveredClockIn && !extPrev;
            if (externalRecoveredClockIn && !extPrev)
            begin
                extBit <= serialRxIn;
            end
        end
    end

    assign recStrobe = bypass ? extStrobe : cdrStrobe;
    assign recBit    = bypass ? extBit : cdrBit;

    // ----------------------------------------------------------------
    // Transmit clock selection and serializer
    // ----------------------------------------------------------------
    // Loop timing picks internal or external recovery by the bypass level.
    always_comb
    begin
        if (!loop_timing_select)
        begin
            txSrc = scl_pkg::SRC_MULT;
        end
        else if (bypass)
        begin
            txSrc = scl_pkg::SRC_EXT;
        end
        else
        begin
            txSrc = scl_pkg::SRC_CDR;
        end
    end

    always_comb
    begin
        case (txSrc)
            scl_pkg::SRC_MULT: serStrobe = multStrobe;
            scl_pkg::SRC_CDR:  serStrobe = cdrStrobe;
            scl_pkg::SRC_EXT:  serStrobe = extStrobe;
            default:           serStrobe = multStrobe;
        endcase
    end

    // Remote loop retimes on the recovered clock whatever the source.
    assign txStrobe = remote ? recStrobe : serStrobe;
    assign loadSlot = clkEn && serStrobe && bitCnt == 3'd7;
    assign fifoPop  = loadSlot && txEn;

    // Load once per eight strobes so no bit is dropped or repeated.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bitCnt <= 3'd7;
            shReg  <= '0;
        end
        else if (clkEn && serStrobe)
        begin
            bitCnt <= bitCnt + 3'd1;
            if (bitCnt == 3'd7)
            begin
                shReg <= (txEn && fifoOutValid) ? fifoOutData : 8'h00;
            end
            else
            begin
                shReg <= {shReg[6:0], 1'b0};
            end
        end
    end

    // Retimer; in digital loop the selected transmit clock keeps transmitting.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            serialTxOut <= 1'b0;
        end
        else if (clkEn && txStrobe)
        begin
            serialTxOut <= remote ? recBit : shReg[7];
        end
    end

    // ----------------------------------------------------------------
    // Word clock pin and word capture
    // ----------------------------------------------------------------
    // Output word clock is high for the first four bits of each word.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            txWordClockOut  <= 1'b0;
            txWordClockOe_n <= 1'b1;
            wcPrev          <= 1'b0;
        end
        else if (clkEn)
        begin
            txWordClockOe_n <= ~ctrl[`SCL_B_CLKOUT];
            wcPrev          <= txWordClockIn;
            if (!ctrl[`SCL_B_CLKOUT])
            begin
                txWordClockOut <= 1'b0;
            end
            else if (serStrobe)
            begin
                txWordClockOut <= ~(bitCnt + 3'd1) >> 2 == 3'd1;
            end
        end
    end

    // Capture at the rising word clock edge, own or supplied.
    assign wordCap = ctrl[`SCL_B_CLKOUT] ? loadSlot
                                         : (clkEn && txWordClockIn && !wcPrev);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pushValid   <= 1'b0;
            pushData    <= '0;
            txDataReady <= 1'b0;
        end
        else if (clkEn)
        begin
            pushValid   <= wordCap && txEn;
            pushData    <= txParallelData;
            txDataReady <= fifoInReady;
        end
    end

    scl_fifo #(
        .W (8),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData),
        .level    (fifoLevel)
    );

    // ----------------------------------------------------------------
    // Receive path and deserializer
    // ----------------------------------------------------------------
    // Digital loop takes serializer bits on the serializer's own strobe.
    assign rxStrobe = digital ? serStrobe : recStrobe;
    assign rxBitIn  = digital ? shReg[7] : recBit;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rxCnt          <= '0;
            rxSh           <= '0;
            rxParallelData <= '0;
            rxWordClockOut <= 1'b0;
        end
        else if (clkEn && rxStrobe)
        begin
            rxCnt          <= rxCnt + 3'd1;
            rxSh           <= {rxSh[5:0], rxBitIn};
            rxWordClockOut <= (rxCnt + 3'd1) < 3'd4;
            if (rxCnt == 3'd7)
            begin
                rxParallelData <= {rxSh, rxBitIn};
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_msbFirst;
        clkEn && serStrobe && bitCnt != 3'd7 |=> shReg[7] == $past(shReg[6]);
    endproperty
    a_msbFirst: assert property (p_msbFirst) else $error("shift order wrong");

    property p_rate;
        clkEn && multStrobe && $stable(divSel) |-> multCnt == divSel - 8'h01;
    endproperty
    a_rate: assert property (p_rate) else $error("bit period wrong");

    property p_lock;
        $rose(locked) |-> refEdgeCnt == 8'(LOCK_EDGES);
    endproperty
    a_lock: assert property (p_lock) else $error("early lock");

    property p_multSrc;
        !loop_timing_select |-> serStrobe == multStrobe;
    endproperty
    a_multSrc: assert property (p_multSrc) else $error("bad tx source");

    property p_cdrSrc;
        loop_timing_select && !bypass && !remote |-> txStrobe == cdrStrobe;
    endproperty
    a_cdrSrc: assert property (p_cdrSrc) else $error("loop timing off");

    property p_extSrc;
        loop_timing_select && bypass && $past(bypass) |-> serStrobe == extStrobe && !cdrStrobe;
    endproperty
    a_extSrc: assert property (p_extSrc) else $error("ext source off");

    property p_remote;
        clkEn && remote && txStrobe |=> serialTxOut == $past(recBit);
    endproperty
    a_remote: assert property (p_remote) else $error("remote loop");

    property p_digital;
        digital |-> rxStrobe == serStrobe && rxBitIn == shReg[7];
    endproperty
    a_digital: assert property (p_digital) else $error("digital loop");

    property p_capture;
        wordCap && txEn && clkEn |=> pushValid && pushData == $past(txParallelData);
    endproperty
    a_capture: assert property (p_capture) else $error("word not taken");

    c_load:   cover property (fifoPop && fifoOutValid);
    c_remote: cover property (remote && txStrobe);
    c_split:  cover property (remote && digital && rxStrobe);
    c_rxWord: cover property (rxStrobe && rxCnt == 3'd7);
endmodule

// ---- tb/scl_framer_model.sv ----
// Purpose: Framer model that presents transmit words to the block.
// Assumes: Runs on ref_clk; the bench resolves the word clock pin.
// Notes:   Its own word clock stands still while switched off.
`timescale 1ns/10ps

module scl_framer_model (
    input  wire logic       ref_clk, // Clock.
    input  wire logic       clkOn,   // Run own word clock.
    input  wire logic [3:0] half,    // Half period in cycles.
    input  wire logic [7:0] word,    // Word to present.
    output logic            wordClk, // Own word clock.
    output logic      [7:0] txData   // Transmit data.
);
    logic [3:0] cnt = 4'h0;

    // Toggle every half cycles; held low when off so no stray capture edge.
    always_ff @(posedge ref_clk)
    begin
        cnt <= (cnt + 4'h1 >= half) ? 4'h0 : cnt + 4'h1;
        if (!clkOn)
            wordClk <= 1'b0;
        else if (cnt == 4'h0)
            wordClk <= !wordClk;
    end

    // A steady word keeps setup and hold met against either clock.
    assign txData = word;
endmodule

// ---- tb/test_scl_loopback_ctrl.sv ----
// Purpose: Self-checking bench for the serializer and loopback block.
// Assumes: Framer model on the word bus; registers over classic Wishbone.
// Notes:   The word 0xD0 is sent; its bit reversal is no rotation of it.
`timescale 1ns/10ps
`include "scl_params.svh"

module test_scl_loopback_ctrl;
    logic        ref_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] datI = 32'h0, datO, q;
    logic        ack, refA = 1'b0, rxIn = 1'b0, clkOn = 1'b0, wcIn, wcOut, oeN;
    logic        fmClk, rdy, txOut, rxClk;
    logic [3:0]  half = 4'h8;
    logic [7:0]  txData, rxData;
    int          error_cnt = 0, num_checks = 0;
    logic [2:0]  extDiv = 3'h0;

    always #5 ref_clk = !ref_clk;
    always @(posedge ref_clk) refA <= !refA; // Reference toggles every cycle.
    always @(posedge ref_clk) extDiv <= extDiv + 3'h1; // External clock, one bit per 8.
    assign wcIn = oeN ? fmClk : wcOut; // Pin level from both drivers.

    scl_loopback_ctrl dut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
        .wb_dat_o(datO), .wb_ack_o(ack), .diffRefClockIn(refA),
        .singleEndedRefClockIn(1'b0), .serialRxIn(rxIn), .externalRecoveredClockIn(extDiv[2]),
        .txParallelData(txData), .txWordClockIn(wcIn), .txWordClockOut(wcOut),
        .txWordClockOe_n(oeN), .txDataReady(rdy), .serialTxOut(txOut),
        .rxParallelData(rxData), .rxWordClockOut(rxClk));
    scl_framer_model fm (.ref_clk(ref_clk), .clkOn(clkOn), .half(half), .word(8'hD0),
        .wordClk(fmClk), .txData(txData));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Any rotation of the sent word counts: the receive word boundary is free.
    function automatic logic rot(input logic [7:0] r);
        logic h;
        h = 1'b0;
        for (int k = 0; k < 8; k++)
            h = h | (8'({r, r} >> k) === 8'hD0);
        return h;
    endfunction

    // Ack and read data are taken at the rising edge that samples ack high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {cyc, stb, we, adr, sel, datI} <= {2'b11, w, a, s, d};
        do @(posedge ref_clk); while (ack !== 1'b1 && ++n < 20);
        q = datO;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1)
            error_cnt++;
    endtask

    // Rebuilds the line stream from one sample per bit.
    task automatic stream(input int div, output logic hit);
        logic [7:0] sr;
        sr = 8'h00;
        hit = 1'b0;
        repeat (200)
        begin
            repeat (div) @(negedge ref_clk);
            sr = {sr[6:0], txOut};
            hit = hit | (sr === 8'hD0);
        end
    endtask

    task automatic go(input logic [31:0] c);
        int n;
        n = 0;
        wb(1'b1, `SCL_CTRL_OFS, 4'hF, c);
        do wb(1'b0, `SCL_STAT_OFS, 4'hF, 0); while (q[0] !== 1'b1 && ++n < 40);
        chk(q[`SCL_S_LOCKED], 1'b1);
        repeat (40) @(posedge ref_clk);
    endtask

    task automatic t_regs;
        wb(1'b0, `SCL_CTRL_OFS, 4'hF, 0);
        chk(q, `SCL_CTRL_RST);
        wb(1'b1, `SCL_CTRL_OFS, 4'h0, 32'hFF);
        wb(1'b0, `SCL_CTRL_OFS, 4'hF, 0);
        chk(q, `SCL_CTRL_RST);
        wb(1'b0, 8'h08, 4'hF, 0);
        chk(q, 0);
    endtask

    task automatic t_out;
        logic h;
        go(32'hE8);
        stream(2, h);
        chk(h, 1'b1);
        chk(oeN, 1'b0);
        chk(rot(rxData), 1'b1);
    endtask

    task automatic t_remote;
        int ones, hi, wc;
        ones = 0;
        hi = 0;
        wc = 0;
        @(posedge ref_clk);
        rxIn <= 1'b1;
        go(32'hE4);
        repeat (32)
        begin
            @(negedge ref_clk);
            ones += int'(txOut === 1'b1);
            hi += int'(rxClk === 1'b1);
            wc += int'(wcOut === 1'b1);
        end
        chk(ones, 32);
        chk(hi, 16);
        chk(wc, 16);
        chk(rxData, 8'hFF);
        @(posedge ref_clk);
        rxIn <= 1'b0;
    endtask

    task automatic t_in;
        logic h;
        @(posedge ref_clk);
        clkOn <= 1'b1;
        go(32'hA8);
        stream(2, h);
        chk(h, 1'b1);
        chk({oeN, wcOut}, 2'b10);
        go(32'hC8);
        stream(8, h);
        chk(h, 1'b1);
    endtask

    // External then internal recovered clock as the transmit source.
    task automatic t_ext;
        logic h;
        go(32'hEB);
        stream(8, h);
        chk(h, 1'b1);
        go(32'hE9);
        stream(2, h);
        chk(h, 1'b1);
    endtask

    // Analog loop: the line stream is recovered back into a receive word.
    task automatic t_ana;
        logic h;
        go(32'hF0);
        stream(2, h);
        chk(h, 1'b1);
        chk(rot(rxData), 1'b1);
    endtask

    // A framer clock twice the drain rate overruns the FIFO.
    task automatic t_fifo;
        int n;
        n = 0;
        @(posedge ref_clk);
        half <= 4'h4;
        go(32'hA8);
        while (rdy !== 1'b0 && ++n < 400) @(negedge ref_clk);
        chk(rdy, 1'b0);
        // Within two more framer words one lands on a full FIFO.
        repeat (24) @(posedge ref_clk);
        wb(1'b0, `SCL_STAT_OFS, 4'hF, 0);
        chk(q[`SCL_S_OVERFLOW], 1'b1);
        @(posedge ref_clk);
        clkOn <= 1'b0;
        repeat (300) @(posedge ref_clk);
        wb(1'b0, `SCL_STAT_OFS, 4'hF, 0);
        chk(q[`SCL_S_UNDERRUN], 1'b1);
        wb(1'b1, `SCL_CTRL_OFS, 4'hF, 32'h28);
        wb(1'b1, `SCL_STAT_OFS, 4'hF, 32'h6);
        wb(1'b0, `SCL_STAT_OFS, 4'hF, 0);
        chk({q[7:4], q[2:1]}, 6'h00);
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_out();
        t_remote();
        t_in();
        t_ext();
        t_ana();
        t_fifo();
        report_and_stop();
    end

    // Whole run needs about 5700 cycles; this cuts a hang short.
    initial
    begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule
